// ==== include/bip_tally_pkg.sv ====
// Package for the section parity error tally block: map, layouts, event types
package bip_tally_pkg;

   // Register indexes; byte address is four times the index
   localparam logic [15:0] IDX_B1_BYTE3 = 16'h1110;
   localparam logic [15:0] IDX_B1_BYTE2 = 16'h1111;
   localparam logic [15:0] IDX_B1_BYTE1 = 16'h1112;
   localparam logic [15:0] IDX_B1_BYTE0 = 16'h1113;
   localparam logic [15:0] IDX_B2_BYTE3 = 16'h1114;
   localparam logic [15:0] IDX_B2_BYTE2 = 16'h1115;
   localparam logic [15:0] IDX_B2_BYTE1 = 16'h1116;
   localparam logic [15:0] IDX_B2_BYTE0 = 16'h1117;
   localparam logic [15:0] IDX_IRQ_STAT = 16'h1180;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h1181;

   localparam logic [1:0]  WORD_LSB     = 2'h0;
   localparam logic [31:0] TALLY_RESET  = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   localparam logic [1:0]  IRQ_RESET    = 2'h0;
   localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

   // Interrupt bit positions
   localparam int IRQ_B1 = 0;
   localparam int IRQ_B2 = 1;

   // Error report of one frame from the overhead checker
   typedef struct packed {
      logic       frame_end;
      logic [7:0] b1_err_bits;
      logic [7:0] b2_err_bits;
      logic       b1_per_frame;
      logic       b2_per_frame;
   } frame_report_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   function automatic logic [3:0] ones_count(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

endpackage

// ==== hdl/parity_tally_counter.sv ====
// One 32-bit parity error tally with per-byte clear-on-read
`timescale 1ns/10ps
`default_nettype none
module parity_tally_counter
   import bip_tally_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        add_en,
   input  wire logic [7:0]  err_bits,
   input  wire logic        per_frame,
   input  wire logic [3:0]  byte_clear,
   output logic      [31:0] tally,
   output logic             counted
);

   typedef struct packed {
      logic [31:0] tally;
      logic        counted;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [31:0] inc;
   logic [31:0] sum;

   always_comb begin
      s_d = s_q;
      inc = DATA_ZERO;
      if (add_en && (err_bits != BYTE_RESET)) begin
         if (per_frame) begin
            inc = 32'h0000_0001;
         end else begin
            inc = {28'h0, ones_count(err_bits)};
         end
      end
      sum = s_q.tally + inc;
      for (int b = 0; b < 4; b++) begin
         if (byte_clear[b]) begin
            sum[b*8 +: 8] = BYTE_RESET;
         end
      end
      s_d.tally   = sum;
      s_d.counted = (inc != DATA_ZERO);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{tally: TALLY_RESET, counted: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign tally   = s_q.tally;
   assign counted = s_q.counted;

   chk_tally_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
      byte_clear[0] |=> tally[7:0] == BYTE_RESET) else $error("tally byte not cleared");
   chk_frame_adds_one: assert property (@(posedge pclk) disable iff (!presetn)
      (add_en && per_frame && err_bits != 8'h00 && byte_clear == 4'h0)
      |=> tally == $past(tally) + 32'h1) else $error("per-frame add not one");
   chk_bit_adds_count: assert property (@(posedge pclk) disable iff (!presetn)
      (add_en && !per_frame && byte_clear == 4'h0)
      |=> tally == $past(tally) + {28'h0, ones_count($past(err_bits))})
      else $error("per-bit add wrong");
   chk_idle_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (!add_en && byte_clear == 4'h0) |=> $stable(tally))
      else $error("tally moved without event");

endmodule
`default_nettype wire

// ==== hdl/section_bip_error_counters.sv ====
// APB register bank holding the regenerator and multiplex parity error tallies
`timescale 1ns/10ps
`default_nettype none
module section_bip_error_counters
   import bip_tally_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_end,
   input  wire logic [7:0]  b1_err_bits,
   input  wire logic [7:0]  b2_err_bits,
   input  wire logic        b1_per_frame,
   input  wire logic        b2_per_frame,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic        b1_per_frame;
      logic        b2_per_frame;
   } state_type;

   state_type        s_q;
   state_type        s_d;
   frame_report_type rep;
   apb_req_type      req;
   logic [31:0]      b1_tally;
   logic [31:0]      b2_tally;
   logic             b1_counted;
   logic             b2_counted;
   logic [3:0]       b1_clear;
   logic [3:0]       b2_clear;
   logic             access;
   logic [15:0]      idx;

   assign rep = '{frame_end: frame_end, b1_err_bits: b1_err_bits,
                  b2_err_bits: b2_err_bits, b1_per_frame: b1_per_frame,
                  b2_per_frame: b2_per_frame};
   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   // Access phase lasts two cycles after setup since pready rises one
   // clock after penable; the read clears on that completing edge
   assign access = req.psel && req.penable && s_q.pready;
   assign idx    = req.paddr[17:2];

   ////////////////////////////////////////////////////////////////////////////
   // Tallies

   parity_tally_counter u_b1 (
      .pclk       (pclk),
      .presetn    (presetn),
      .add_en     (rep.frame_end),
      .err_bits   (rep.b1_err_bits),
      .per_frame  (s_q.b1_per_frame),
      .byte_clear (b1_clear),
      .tally      (b1_tally),
      .counted    (b1_counted)
   );

   parity_tally_counter u_b2 (
      .pclk       (pclk),
      .presetn    (presetn),
      .add_en     (rep.frame_end),
      .err_bits   (rep.b2_err_bits),
      .per_frame  (s_q.b2_per_frame),
      .byte_clear (b2_clear),
      .tally      (b2_tally),
      .counted    (b2_counted)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register decode and next state

   always_comb begin
      s_d      = s_q;
      b1_clear = 4'h0;
      b2_clear = 4'h0;
      s_d.pready  = req.psel && req.penable && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata  = DATA_ZERO;
      // Mode latched at each frame end; takes effect for the next frame
      if (rep.frame_end) begin
         s_d.b1_per_frame = rep.b1_per_frame;
         s_d.b2_per_frame = rep.b2_per_frame;
      end
      if (req.psel && req.penable && !s_q.pready) begin
         if (req.paddr[1:0] != WORD_LSB || req.paddr[31:18] != 14'h0) begin
            s_d.pslverr = 1'b1;
         end else if (idx == IDX_B1_BYTE3) begin
            s_d.prdata = {24'h0, b1_tally[31:24]};
         end else if (idx == IDX_B1_BYTE2) begin
            s_d.prdata = {24'h0, b1_tally[23:16]};
         end else if (idx == IDX_B1_BYTE1) begin
            s_d.prdata = {24'h0, b1_tally[15:8]};
         end else if (idx == IDX_B1_BYTE0) begin
            s_d.prdata = {24'h0, b1_tally[7:0]};
         end else if (idx == IDX_B2_BYTE3) begin
            s_d.prdata = {24'h0, b2_tally[31:24]};
         end else if (idx == IDX_B2_BYTE2) begin
            s_d.prdata = {24'h0, b2_tally[23:16]};
         end else if (idx == IDX_B2_BYTE1) begin
            s_d.prdata = {24'h0, b2_tally[15:8]};
         end else if (idx == IDX_B2_BYTE0) begin
            s_d.prdata = {24'h0, b2_tally[7:0]};
         end else if (idx == IDX_IRQ_STAT) begin
            s_d.prdata = {30'h0, s_q.stat};
         end else if (idx == IDX_IRQ_MASK) begin
            s_d.prdata = {30'h0, s_q.mask};
         end else begin
            s_d.pslverr = 1'b1;
         end
         if (req.pwrite) begin
            s_d.prdata = DATA_ZERO;
         end
      end
      if (access) begin
         if (!req.pwrite && idx[15:3] == IDX_B1_BYTE3[15:3] && !s_q.pslverr) begin
            if (idx[2]) begin
               b2_clear[3 - idx[1:0]] = 1'b1;
            end else begin
               b1_clear[3 - idx[1:0]] = 1'b1;
            end
         end
         if (req.pwrite && idx == IDX_IRQ_MASK && !s_q.pslverr) begin
            s_d.mask = req.pwdata[1:0];
         end
         if (req.pwrite && idx == IDX_IRQ_STAT && !s_q.pslverr) begin
            s_d.stat = s_q.stat & ~req.pwdata[1:0];
         end
      end
      // Set wins over a simultaneous write-one clear
      if (b1_counted) begin
         s_d.stat[IRQ_B1] = 1'b1;
      end
      if (b2_counted) begin
         s_d.stat[IRQ_B2] = 1'b1;
      end
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{prdata: DATA_ZERO, pready: 1'b0, pslverr: 1'b0, irq: 1'b0,
                  stat: IRQ_RESET, mask: IRQ_RESET, b1_per_frame: 1'b0,
                  b2_per_frame: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq     = s_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence read_done_s(logic [15:0] a);
      psel && penable && pready && !pwrite && idx == a && !pslverr;
   endsequence

   chk_b1_msb_clear: assert property (@(posedge pclk) disable iff (!presetn)
      read_done_s(IDX_B1_BYTE3) |=> b1_tally[31:24] == BYTE_RESET)
      else $error("b1 byte3 not cleared");
   chk_b2_lsb_clear: assert property (@(posedge pclk) disable iff (!presetn)
      read_done_s(IDX_B2_BYTE0) |=> b2_tally[7:0] == BYTE_RESET)
      else $error("b2 byte0 not cleared");
   chk_b1_byte2_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !pwrite && idx == IDX_B1_BYTE2 && paddr[1:0] == 2'h0)
      |=> prdata == {24'h0, $past(b1_tally[23:16])}) else $error("b1 byte2 data");
   chk_b2_byte3_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !pwrite && idx == IDX_B2_BYTE3 && paddr[1:0] == 2'h0)
      |=> prdata == {24'h0, $past(b2_tally[31:24])}) else $error("b2 byte3 data");
   chk_b2_frame_one: assert property (@(posedge pclk) disable iff (!presetn)
      (frame_end && s_q.b2_per_frame && b2_err_bits != 8'h00 && !access)
      |=> b2_tally == $past(b2_tally) + 32'h1) else $error("b2 frame add");
   chk_b2_bit_count: assert property (@(posedge pclk) disable iff (!presetn)
      (frame_end && !s_q.b2_per_frame && !access)
      |=> b2_tally == $past(b2_tally) + {28'h0, ones_count($past(b2_err_bits))})
      else $error("b2 bit add");
   chk_b2_advances: assert property (@(posedge pclk) disable iff (!presetn)
      (frame_end && b2_err_bits != 8'h00 && !access) |=> b2_tally != $past(b2_tally))
      else $error("b2 tally stuck");
   chk_mode_sampled: assert property (@(posedge pclk) disable iff (!presetn)
      frame_end |=> s_q.b1_per_frame == $past(b1_per_frame)
      && s_q.b2_per_frame == $past(b2_per_frame)) else $error("mode not sampled");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      b1_counted && s_q.mask[0] && !access |=> irq) else $error("irq missing");

endmodule
`default_nettype wire

// ==== testbench/frame_source.sv ====
// Model of the incoming line stream that feeds one frame report per cycle while send is high
`timescale 1ns/10ps
`default_nettype none
module frame_source
   import bip_tally_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        send,
   input  wire logic [7:0]  e1,
   input  wire logic [7:0]  e2,
   input  wire logic        m1,
   input  wire logic        m2,
   output var frame_report_type rpt
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpt <= '0;
      end else if (send) begin
         rpt <= '{1'b1, e1, e2, m1, m2};
      end else begin
         // Error bits mean nothing between frames, so they keep toggling
         rpt <= '{1'b0, ~rpt.b1_err_bits, ~rpt.b2_err_bits, m1, m2};
      end
   end
endmodule
`default_nettype wire

// ==== testbench/section_bip_error_counters_test.sv ====
// Register-level test of the section parity error tally block
`timescale 1ns/10ps
`default_nettype none
module section_bip_error_counters_test
   import bip_tally_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic send, m1, m2, lat1, lat2;
   logic [7:0] e1, e2;
   logic [31:0] exp1, exp2;
   frame_report_type rpt;
   int error_cnt, checked;

   frame_source frame_source_inst (.pclk(pclk), .presetn(presetn), .send(send), .e1(e1),
      .e2(e2), .m1(m1), .m2(m2), .rpt(rpt));
   section_bip_error_counters section_bip_error_counters_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_end(rpt.frame_end),
      .b1_err_bits(rpt.b1_err_bits), .b2_err_bits(rpt.b2_err_bits),
      .b1_per_frame(rpt.b1_per_frame), .b2_per_frame(rpt.b2_per_frame), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] data, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {14'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         report_and_stop();
      end
      data = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reads the four bytes of a tally, most significant first
   task automatic chk_tally(input string what, input logic [15:0] base, input logic [31:0] exp);
      logic [31:0] v;
      logic e;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, base + 16'(i), DATA_ZERO, rd, e);
         v = {v[23:0], rd[7:0]};
      end
      chk_val(what, exp, v);
   endtask

   function automatic logic [31:0] pop(input logic [7:0] v);
      pop = 32'h0;
      for (int i = 0; i < 8; i++) begin
         pop = pop + 32'(v[i]);
      end
   endfunction

   task automatic frames(input int n, input logic [7:0] a, input logic [7:0] b);
      // Mode inputs set just before the call have settled after this edge
      @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         exp1 = exp1 + (lat1 ? 32'(a != 8'h00) : pop(a));
         exp2 = exp2 + (lat2 ? 32'(b != 8'h00) : pop(b));
         lat1 = m1;
         lat2 = m2;
      end
      send <= 1'b1;
      e1 <= a;
      e2 <= b;
      repeat (n) @(posedge pclk);
      send <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic chk_irq(input logic exp);
      repeat (2) @(negedge pclk);
      chk_val("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   initial begin
      logic e;
      {psel, penable, pwrite, paddr, pwdata, send, m1, m2, e1, e2} = '0;
      {lat1, lat2, exp1, exp2, error_cnt, checked} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, IDX_B1_BYTE3 + 16'(i), DATA_ZERO, rd, e);
         chk_val("reset byte", 32'h0, {24'h0, rd[7:0]});
      end
      apb(1'b0, IDX_IRQ_MASK, DATA_ZERO, rd, e);
      chk_val("mask reset", 32'h0, rd);
      $display("test reset done");

      frames(1, 8'h05, 8'h81);
      frames(2, 8'hFF, 8'h00);
      chk_tally("b1 per bit", IDX_B1_BYTE3, exp1);
      chk_tally("b2 per bit", IDX_B2_BYTE3, exp2);
      chk_tally("b1 cleared", IDX_B1_BYTE3, 32'h0);
      chk_tally("b2 cleared", IDX_B2_BYTE3, 32'h0);
      $display("test per bit done");

      {exp1, exp2} = '0;
      frames(40, 8'hFF, 8'hFF);
      apb(1'b1, IDX_B1_BYTE0, 32'h0000_00AA, rd, e);
      chk_tally("b1 carry", IDX_B1_BYTE3, exp1);
      chk_tally("b2 carry", IDX_B2_BYTE3, exp2);
      $display("test carry done");

      {exp1, exp2} = '0;
      m1 <= 1'b1;
      m2 <= 1'b1;
      frames(1, 8'h00, 8'h00);
      frames(2, 8'hFF, 8'h10);
      frames(1, 8'h00, 8'h00);
      m2 <= 1'b0;
      frames(1, 8'h01, 8'h00);
      frames(1, 8'h80, 8'h03);
      chk_tally("b1 per frame", IDX_B1_BYTE3, exp1);
      chk_tally("b2 per frame", IDX_B2_BYTE3, exp2);
      $display("test per frame done");

      apb(1'b1, IDX_IRQ_STAT, 32'h0000_0003, rd, e);
      apb(1'b1, IDX_IRQ_MASK, 32'h0000_0001, rd, e);
      frames(1, 8'h01, 8'h01);
      chk_irq(1'b1);
      apb(1'b0, IDX_IRQ_STAT, DATA_ZERO, rd, e);
      chk_val("status", 32'h3, {30'h0, rd[1:0]});
      apb(1'b1, IDX_IRQ_MASK, 32'h0000_0002, rd, e);
      chk_irq(1'b1);
      apb(1'b1, IDX_IRQ_STAT, 32'h0000_0002, rd, e);
      chk_irq(1'b0);
      apb(1'b1, IDX_IRQ_MASK, 32'h0000_0001, rd, e);
      chk_irq(1'b1);
      apb(1'b1, IDX_IRQ_STAT, 32'h0000_0001, rd, e);
      chk_irq(1'b0);
      apb(1'b0, 16'h1190, DATA_ZERO, rd, e);
      chk_val("unmapped error", 32'h1, {31'h0, e});
      $display("test interrupt done");
      report_and_stop();
   end
endmodule
`default_nettype wire
